// ==== core/lmu_pkg.sv ====
// Purpose: Shared constants and types for the LED mode and user registers
// Assumes: APB with 32-bit data, one register per aligned word
// Notes: Printed offsets are not multiples of four, so they are indices
package lmu_pkg;
    localparam int ADDR_W = 8;
    localparam int NUM_PORTS = 3;
    // Register indices as printed; byte address is four times the index
    localparam logic [5:0] IDX_GCTL9 = 6'h0b;
    localparam logic [5:0] IDX_RSVD = 6'h0c;
    localparam logic [5:0] IDX_USER1 = 6'h0d;
    localparam logic [5:0] IDX_USER2 = 6'h0e;
    localparam logic [5:0] IDX_USER3 = 6'h0f;
    localparam logic [5:0] IDX_PORT_BASE = 6'h10;
    localparam logic [5:0] IDX_PORT_STRIDE = 6'h10;
    localparam logic [5:0] IDX_STATUS = 6'h3f;
    // Control register 9 field positions
    localparam int GC9_TPID_BIT = 0;
    localparam int GC9_LEDMODE_BIT = 1;
    localparam int GC9_RSVD2_BIT = 2;
    localparam int GC9_RSVD3_BIT = 3;
    localparam int GC9_TEST_BIT = 4;
    localparam int GC9_RSVD5_BIT = 5;
    localparam int GC9_PSAVE_BIT = 6;
    // Reset value with LED mode bit left clear; strap fills it in
    localparam logic [7:0] GC9_RESET = 8'h08;
    localparam logic [7:0] RSVD_RESET = 8'h00;
    localparam logic [7:0] USER_RESET = 8'h00;
    localparam logic [7:0] PORT_CTL_RESET = 8'h00;
    localparam logic [1:0] LED_SEL_00 = 2'h0;
    localparam logic [1:0] LED_SEL_01 = 2'h1;
    localparam logic [1:0] LED_SEL_10 = 2'h2;
    localparam logic [1:0] LED_SEL_11 = 2'h3;

    // Per-port link state as seen by the indicator mapper
    typedef struct packed {
        logic link;
        logic activity;
        logic speed_100;
        logic full_duplex;
        logic collision;
    } lmu_port_state_t;

    // Four indicators of one port
    typedef struct packed {
        logic three;
        logic two;
        logic one;
        logic zero;
    } lmu_leds_t;

    typedef struct packed {
        logic sel;
        logic enable;
        logic write;
        logic [ADDR_W-1:0] addr;
        logic [31:0] wdata;
    } lmu_apb_req_t;

    typedef struct packed {
        logic ready;
        logic slverr;
        logic [31:0] rdata;
    } lmu_apb_rsp_t;
endpackage : lmu_pkg

// ==== core/lmu_led_map.sv ====
// Purpose: Maps one port's link state onto its four indicators
// Assumes: State inputs are synchronous levels, active high
// Notes: Output is registered so the pins never glitch on a mode change
`timescale 1ns/1ps
module lmu_led_map (
    input wire logic CLK,
    input wire logic RST,
    input wire logic [1:0] sel,
    input wire lmu_pkg::lmu_port_state_t state,
    output lmu_pkg::lmu_leds_t leds
);
    import lmu_pkg::*;

    lmu_leds_t leds_reg;
    lmu_leds_t leds_next;

    always_comb begin
        leds_next = '0;
        unique case (sel)
            LED_SEL_00: begin
                leds_next.two = state.link & state.activity; // RL3
                leds_next.one = state.full_duplex | state.collision; // RL3
                leds_next.zero = state.speed_100; // RL3
            end
            LED_SEL_01: begin
                leds_next.two = state.link & state.activity
                    & state.speed_100; // RL3
                leds_next.one = state.link & state.activity
                    & ~state.speed_100; // RL3
                leds_next.zero = state.full_duplex; // RL3
            end
            LED_SEL_10: begin
                leds_next.three = state.activity; // RL4
                leds_next.two = state.link; // RL4
                leds_next.one = state.full_duplex | state.collision; // RL4
                leds_next.zero = state.speed_100; // RL4
            end
            LED_SEL_11: begin
                leds_next = '0; // RL4
            end
        endcase
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            leds_reg <= '0;
        end else begin
            leds_reg <= leds_next;
        end
    end

    assign leds = leds_reg;
endmodule : lmu_led_map

// ==== core/lmu_regs.sv ====
// Purpose: Global control 9, reserved and user bytes, per-port controls
// Assumes: APB slave, zero wait states, straps stable around reset
// Notes: Unmapped addresses read zero and answer with pslverr
// Operation
// RL1: The LED mode bit is the low LED select, loaded from its strap at reset.
// RL2: The high LED select comes only from its strap, caught at reset.
// RL3: Selections 00 and 01 drive the indicators as the two base layouts.
// RL4: Selection 10 adds an activity indicator; 11 drives nothing.
// RL5: A reserved byte at index 0x0c resets to zero and is read-only.
// RL6: Three user bytes at indices 0x0d to 0x0f are plain read/write.
// RL7: Software leaves reserved bits 3 and 2 at their reset values 1 and 0.
// RL8: Every port control register shares one layout at its own address.
// RL9: Software keeps the testing bit 4 clear in normal use.
//
// Our own choice: the APB slave port.
`timescale 1ns/1ps
module lmu_regs #(
    parameter int PORTS = lmu_pkg::NUM_PORTS
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [lmu_pkg::ADDR_W-1:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [3:0] PSTRB,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic LED_SELECT_LOW_STRAP,
    input wire logic LED_SELECT_HIGH_STRAP,
    input wire lmu_pkg::lmu_port_state_t [PORTS-1:0] PORT_STATE,
    output lmu_pkg::lmu_leds_t [PORTS-1:0] PORT_LEDS,
    output logic [7:0] PORT_CTL [PORTS],
    output logic SPECIAL_TPID_MODE,
    output logic PHY_POWER_SAVE,
    output logic TEST_MODE
);
    import lmu_pkg::*;

    logic [7:0] gc9_reg;
    logic led_select_high_reg;
    logic [7:0] user_reg [3];
    logic [7:0] port_ctl_reg [PORTS];
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic slverr_reg;
    logic slverr_next;
    logic in_reset_reg;
    logic [5:0] idx;
    logic wr_acc;
    logic rd_acc;
    logic [1:0] led_sel;

    // Index from byte address; low two bits ignored
    assign idx = PADDR[7:2];
    assign wr_acc = PSEL & PENABLE & PWRITE & PSTRB[0];
    assign rd_acc = PSEL & PENABLE & ~PWRITE;

    // Port number owning an index, or PORTS when none
    function automatic int port_of(input logic [5:0] i);
        int p;
        p = PORTS;
        for (int k = 0; k < PORTS; k++) begin
            if (i == 6'(IDX_PORT_BASE + 6'(k) * IDX_PORT_STRIDE)) begin
                p = k;
            end
        end
        return p;
    endfunction : port_of

    function automatic logic is_mapped(input logic [5:0] i);
        return (i >= IDX_GCTL9 && i <= IDX_USER3) || i == IDX_STATUS
            || port_of(i) != PORTS;
    endfunction : is_mapped

    // Straps caught on the first clock after reset release
    always_ff @(posedge CLK) begin
        in_reset_reg <= RST;
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            gc9_reg <= GC9_RESET;
        end else if (in_reset_reg) begin
            gc9_reg[GC9_LEDMODE_BIT] <= LED_SELECT_LOW_STRAP; // RL1
        end else if (wr_acc && idx == IDX_GCTL9) begin
            // Reserved bits 7 stays zero; 3 and 2 are left to software
            gc9_reg <= {1'b0, PWDATA[6:0]}; // RL1 RL7 RL9
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            led_select_high_reg <= 1'b0;
        end else if (in_reset_reg) begin
            led_select_high_reg <= LED_SELECT_HIGH_STRAP; // RL2
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            user_reg <= '{default: USER_RESET};
        end else if (wr_acc && idx >= IDX_USER1 && idx <= IDX_USER3) begin
            user_reg[2'(idx - IDX_USER1)] <= PWDATA[7:0]; // RL6
        end
    end

    // Same layout per port, one decode for all copies
    always_ff @(posedge CLK) begin
        if (RST) begin
            port_ctl_reg <= '{default: PORT_CTL_RESET};
        end else if (wr_acc && port_of(idx) != PORTS) begin
            port_ctl_reg[port_of(idx)] <= PWDATA[7:0]; // RL8
        end
    end

    assign led_sel = {led_select_high_reg, gc9_reg[GC9_LEDMODE_BIT]}; // RL2

    always_comb begin
        rdata_next = '0;
        if (idx == IDX_GCTL9) begin
            rdata_next[7:0] = gc9_reg;
        end else if (idx == IDX_RSVD) begin
            rdata_next[7:0] = RSVD_RESET; // RL5
        end else if (idx >= IDX_USER1 && idx <= IDX_USER3) begin
            rdata_next[7:0] = user_reg[2'(idx - IDX_USER1)]; // RL6
        end else if (idx == IDX_STATUS) begin
            rdata_next[1:0] = led_sel;
        end else if (port_of(idx) != PORTS) begin
            rdata_next[7:0] = port_ctl_reg[port_of(idx)]; // RL8
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            rdata_reg <= '0;
        end else if (PSEL && !PENABLE && !PWRITE) begin
            rdata_reg <= rdata_next;
        end
    end

    assign slverr_next = ~is_mapped(idx);

    always_ff @(posedge CLK) begin
        if (RST) begin
            slverr_reg <= 1'b0;
        end else if (PSEL && !PENABLE) begin
            slverr_reg <= slverr_next;
        end
    end

    // Zero wait states; data prepared during setup
    assign PREADY = 1'b1;
    assign PRDATA = rd_acc ? rdata_reg : '0;
    assign PSLVERR = PSEL & PENABLE & slverr_reg;

    genvar g;
    generate
        for (g = 0; g < PORTS; g++) begin : gen_port
            lmu_led_map u_map (
                .CLK(CLK),
                .RST(RST),
                .sel(led_sel),
                .state(PORT_STATE[g]),
                .leds(PORT_LEDS[g])
            );
        end
    endgenerate

    assign PORT_CTL = port_ctl_reg;
    assign SPECIAL_TPID_MODE = gc9_reg[GC9_TPID_BIT];
    assign PHY_POWER_SAVE = gc9_reg[GC9_PSAVE_BIT];
    assign TEST_MODE = gc9_reg[GC9_TEST_BIT];
endmodule : lmu_regs

// ==== verif/lmu_regs_properties.sv ====
// Purpose: Port-level properties of the LED mode and user registers
// Assumes: APB with zero wait states, synchronous active-high reset
// Notes: Read data is checked in the access phase and must stay zero outside it
`timescale 1ns/1ps
module lmu_regs_properties #(
    parameter int PORTS = 3
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [3:0] PSTRB,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic [7:0] PORT_CTL [PORTS],
    input wire logic SPECIAL_TPID_MODE,
    input wire logic PHY_POWER_SAVE,
    input wire logic TEST_MODE
);
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    wire acc = PSEL && PENABLE;
    wire wr = acc && PWRITE && PSTRB[0];
    property p_ready; PREADY; endproperty
    a_ready: assert property (p_ready) else $error("pready low");
    property p_unmapped; acc && PADDR == 8'h20 |-> PSLVERR && PRDATA == 0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("no slave error");
    property p_mapped;
        acc && PADDR inside {8'h2c, 8'h30, 8'h34, 8'h38, 8'h3c} |-> !PSLVERR;
    endproperty
    a_mapped: assert property (p_mapped) else $error("bad slave error");
    property p_rsvd; acc && PADDR == 8'h30 |-> PRDATA == 32'h0; endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved not zero");
    property p_user;
        wr && PADDR inside {8'h34, 8'h38, 8'h3c} ##1
        PSEL && !PWRITE && PADDR == $past(PADDR) ##1 acc
        |-> PRDATA == {24'h0, $past(PWDATA[7:0], 2)};
    endproperty
    a_user: assert property (p_user) else $error("user readback");
    property p_ctl9; wr && PADDR == 8'h2c |=> TEST_MODE == $past(PWDATA[4])
        && PHY_POWER_SAVE == $past(PWDATA[6])
        && SPECIAL_TPID_MODE == $past(PWDATA[0]);
    endproperty
    a_ctl9: assert property (p_ctl9) else $error("control bits");
    property p_idle; !acc |-> PRDATA == 32'h0 && !PSLVERR; endproperty
    a_idle: assert property (p_idle) else $error("data outside access");
    for (genvar p = 0; p < PORTS; p++) begin : g_port
        property p_port; wr && PADDR == 8'(64 * (p + 1))
            |=> PORT_CTL[p] == $past(PWDATA[7:0]); endproperty
        a_port: assert property (p_port) else $error("port control");
    end
    c_user: cover property (wr && PADDR == 8'h34 ##2 acc);
    c_err: cover property (acc && PSLVERR);
    c_ctl9: cover property (wr && PADDR == 8'h2c);
endmodule : lmu_regs_properties
bind lmu_regs lmu_regs_properties #(.PORTS(PORTS)) i_props (.CLK(CLK),
    .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .PORT_CTL(PORT_CTL),
    .SPECIAL_TPID_MODE(SPECIAL_TPID_MODE), .PHY_POWER_SAVE(PHY_POWER_SAVE),
    .TEST_MODE(TEST_MODE));

// ==== verif/lmu_regs_test.sv ====
// Purpose: Self-checking bench for the LED mode and user registers
// Assumes: Zero wait-state APB slave, straps caught at reset end
// Notes: Third reset moves the high select strap
`timescale 1ns/1ps
module lmu_regs_test;
    import lmu_pkg::*;
    logic CLK = 0, RST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0, sl = 0, sh = 0;
    logic [7:0] PADDR = 0, d;
    logic [31:0] PWDATA = 0, PRDATA, rnd = 72564;
    logic PREADY, PSLVERR, TEST_MODE, PHY_POWER_SAVE, SPECIAL_TPID_MODE;
    lmu_port_state_t [2:0] ps = '0;
    lmu_leds_t [2:0] leds;
    logic [7:0] pctl [3];
    logic [32:0] expq [$];
    int n_fail = 0, n_compared = 0;
    lmu_regs i_dut (.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(4'hf),
        .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
        .LED_SELECT_LOW_STRAP(sl), .LED_SELECT_HIGH_STRAP(sh),
        .PORT_STATE(ps), .PORT_LEDS(leds), .PORT_CTL(pctl),
        .SPECIAL_TPID_MODE(SPECIAL_TPID_MODE),
        .PHY_POWER_SAVE(PHY_POWER_SAVE), .TEST_MODE(TEST_MODE));
    always #4 CLK = ~CLK;
    function automatic logic [31:0] nx(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : nx
    function automatic lmu_leds_t ledm(logic [1:0] s, lmu_port_state_t p);
        logic la;
        la = p.link & p.activity;
        case (s)
            LED_SEL_00: return {1'b0, la, p.full_duplex | p.collision,
                p.speed_100};
            LED_SEL_01: return {1'b0, la & p.speed_100, la & ~p.speed_100,
                p.full_duplex};
            LED_SEL_10: return {p.activity, p.link,
                p.full_duplex | p.collision, p.speed_100};
            default: return 4'h0;
        endcase
    endfunction : ledm
    task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
        n_compared++;
        if (s !== e) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    // Leaves PSEL high so back-to-back calls run with no idle cycle between them
    task automatic apb(logic w, logic [7:0] a, logic [31:0] v, logic [32:0] e);
        if (!w) expq.push_back(e);
        PSEL <= 1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= v;
        @(posedge CLK);
        PENABLE <= 1;
        // PREADY high ends this wait; the watchdog ends the run if it never comes
        do @(posedge CLK); while (PREADY !== 1'b1);
        PENABLE <= 0;
    endtask : apb
    task automatic idle(int n);
        PSEL <= 0;
        repeat (n) @(posedge CLK);
    endtask : idle
    task automatic rst(logic l, logic h);
        RST <= 1;
        sl <= l;
        sh <= h;
        repeat (20) @(posedge CLK);
        RST <= 0;
        repeat (2) @(posedge CLK);
    endtask : rst
    always @(posedge CLK) begin
        if (PSEL && PENABLE && !PWRITE && PREADY) begin
            chk("prdata", expq[0][31:0], PRDATA);
            chk("pslverr", 32'(expq[0][32]), 32'(PSLVERR));
            void'(expq.pop_front());
        end
    end
    task automatic close_out;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : close_out
    initial begin
        repeat (20000) @(posedge CLK);
        n_fail++;
        close_out();
    end
    initial begin
        rst(1, 0);
        apb(0, 8'h2c, 0, 33'h0a);
        apb(0, 8'h30, 0, 0);
        apb(1, 8'h30, 32'hff, 0);
        apb(0, 8'h30, 0, 0);
        apb(0, 8'h20, 0, 33'h100000000);
        for (int i = 0; i < 6; i++) begin
            rnd = nx(rnd);
            d = 8'(i < 3 ? 8'h34 + 4 * i : 64 * (i - 2));
            apb(0, d, 0, 0);
            apb(1, d, rnd, 0);
            apb(0, d, 0, {25'h0, rnd[7:0]});
            idle(1);
            if (i > 2) chk("port_ctl", rnd[7:0], pctl[i - 3]);
        end
        for (int h = 0; h < 2; h++) begin
            rst(0, h[0]);
            for (int l = 0; l < 2; l++) begin
                rnd = nx(rnd);
                d = 8'h08 | 8'(l << 1) | (rnd[7:0] & 8'h51);
                apb(1, 8'h2c, {rnd[31:8], d}, 0);
                apb(0, 8'hfc, 0, 33'(2 * h + l));
                idle(1);
                chk("ctl", d[6:4] & 3'h5, {PHY_POWER_SAVE, 1'b0, TEST_MODE});
                chk("tpid", d[0], SPECIAL_TPID_MODE);
                repeat (6) begin
                    rnd = nx(rnd);
                    ps <= rnd[14:0];
                    repeat (3) @(posedge CLK);
                    for (int p = 0; p < 3; p++)
                        chk("leds", ledm(2'(2 * h + l), ps[p]), leds[p]);
                end
            end
        end
        close_out();
    end
endmodule : lmu_regs_test
